// ### trf_pkg.sv
package trf_pkg;

  // ********************************************************
  // clock and timing
  // ********************************************************
  localparam int unsigned CLK_HZ   = 25_000_000;
  localparam int unsigned MS_CYC   = CLK_HZ / 1000;
  localparam int unsigned DEB_MS   = 20;
  localparam int unsigned PULSE_MS = 100;
  localparam int unsigned SEC_CYC_DEF   = CLK_HZ;
  localparam int unsigned DEB_CYC_DEF   = MS_CYC * DEB_MS;
  localparam int unsigned PULSE_CYC_DEF = MS_CYC * PULSE_MS;

  // field phases in seconds
  localparam int SEC_W = 11;
  localparam int MIN_S = 60;
  localparam logic [SEC_W-1:0] STBY_ON_S = 11'h00A;
  localparam logic [SEC_W-1:0] DC1_ON_S  = 11'h005;
  localparam logic [SEC_W-1:0] DC1_OFF_S = 11'h01E;
  localparam logic [SEC_W-1:0] DC2_ON_S  = 11'h00A;
  localparam logic [SEC_W-1:0] DC2_OFF_S = SEC_W'(5 * MIN_S);
  localparam logic [SEC_W-1:0] DC3_OFF_S = SEC_W'(30 * MIN_S);
  localparam logic [SEC_W-1:0] SEC_ONE   = 11'h001;
  localparam logic [SEC_W-1:0] SEC_ZERO  = 11'h000;
  localparam logic [3:0] QUERY_LAST = 4'hB;
  localparam logic [5:0] REACQ_LAST = 6'h3B;

  // ********************************************************
  // option switch positions (switch n at bit n-1)
  // ********************************************************
  localparam int SW_SUPV = 0;
  localparam int SW_EDGE = 1;
  localparam int SW_IND  = 2;
  localparam int SW_M6   = 5;
  localparam int SW_M7   = 6;
  localparam int SW_M8   = 7;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [7:0] REG_NOM  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int NOM_CLO_LSB = 0;
  localparam int NOM_OPN_LSB = 8;
  localparam int NOM_TOL_LSB = 16;
  localparam logic [7:0] NOM_CLO_RST = 8'h40;
  localparam logic [7:0] NOM_OPN_RST = 8'hC0;
  localparam logic [7:0] NOM_TOL_RST = 8'h10;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_FSM_LSB  = 4;
  localparam int ST_FLT_BIT  = 8;
  localparam int ST_CLS_LSB  = 9;
  localparam int ST_ADDR_LSB = 16;

  typedef enum logic [2:0] {
    MD_TEST = 3'h0, MD_CONT = 3'h1, MD_STBY = 3'h2, MD_DC1 = 3'h3,
    MD_DC2  = 3'h4, MD_DC3  = 3'h5, MD_BAD6 = 3'h6, MD_BAD7 = 3'h7
  } trf_mode_t;

  typedef enum logic [2:0] {
    FS_OFF = 3'b001, FS_ON = 3'b010, FS_ERR = 3'b100
  } trf_fld_t;

  typedef enum logic [1:0] {
    LC_CLOSED = 2'h0, LC_OPEN = 2'h1, LC_FAULT = 2'h2
  } trf_cls_t;

  typedef enum logic [1:0] {
    MK_TAG = 2'h0, MK_MODE_ERR = 2'h1, MK_LINE_FLT = 2'h2
  } trf_kind_t;

  typedef struct packed {
    trf_kind_t   kind;
    logic [7:0]  unit;
    logic [31:0] tag;
  } trf_rpt_t;

endpackage : trf_pkg

// ### trf_field_ctrl.sv
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
// ********************************************************
// tag reader field mode controller
// ********************************************************
// Notes on behaviour
// - mode from switches six, seven, eight
// - test mode: field on, no messages; line fault messages are still sent
// - test tag pulses red and buzzer only
// - off off on: field always on
// - continuous: report tags, query 12 s, reacquire minutely
// - standby: qualifying edge opens field 10 s
// - duty one: 5 s on, 30 s off
// - duty two: 10 s on, 5 min off
// - duty three: 10 s on, 30 min off
// - standby interval forwards every detected tag
// - mode switch change applies while running
// - switch two picks trigger edge
// - switch one enables line end supervision
// - nominal level change means open or close
// - other level sends a fault message
// - unit address from switches, in reports
// - undefined mode: error state and message
// - switch three gates indicators and buzzer
module trf_field_ctrl
  import trf_pkg::*;
#(
  parameter int unsigned SEC_CYC   = SEC_CYC_DEF,
  parameter int unsigned DEB_CYC   = DEB_CYC_DEF,
  parameter int unsigned PULSE_CYC = PULSE_CYC_DEF
)(
  input  logic        clk_sys_i,
  input  logic        srst_i,
  input  logic [7:0]  opt_sw_i,
  input  logic [7:0]  addr_sw_i,
  input  logic        contact_i,
  input  logic [7:0]  line_adc_i,
  input  logic        tag_valid_i,
  input  logic [31:0] tag_id_i,
  output logic        tag_ready_o,
  output logic        rpt_valid_o,
  output trf_rpt_t    rpt_o,
  input  logic        rpt_ready_i,
  output logic        field_en_o,
  output logic        query_o,
  output logic        reacq_o,
  output logic        red_led_o,
  output logic        green_led_o,
  output logic        buzzer_o,
  input  logic        psel_i,
  input  logic        penable_i,
  input  logic        pwrite_i,
  input  logic [7:0]  paddr_i,
  input  logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic        pready_o,
  output logic        pslverr_o
);

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic trf_mode_t mode_of(input logic [7:0] sw);
    return trf_mode_t'({sw[SW_M6], sw[SW_M7], sw[SW_M8]});
  endfunction : mode_of

  function automatic logic is_duty(input trf_mode_t m);
    return (m == MD_DC1) || (m == MD_DC2) || (m == MD_DC3);
  endfunction : is_duty

  function automatic logic [SEC_W-1:0] on_secs(input trf_mode_t m);
    return (m == MD_DC1) ? DC1_ON_S : DC2_ON_S;
  endfunction : on_secs

  function automatic logic [SEC_W-1:0] off_secs(input trf_mode_t m);
    unique case (m)
      MD_DC1:  return DC1_OFF_S;
      MD_DC2:  return DC2_OFF_S;
      MD_DC3:  return DC3_OFF_S;
      default: return SEC_ZERO;
    endcase
  endfunction : off_secs

  function automatic logic near(input logic [7:0] a, input logic [7:0] b,
                                input logic [7:0] tol);
    return ((a > b) ? (a - b) : (b - a)) <= tol;
  endfunction : near

  // ********************************************************
  // synchronise and debounce the pins
  // ********************************************************
  localparam int IN_W = 25;
  logic [IN_W-1:0] raw, s1, s2, samp, deb;
  logic [IN_W-1:0] next_samp, next_deb;
  logic [31:0]     dcnt, next_dcnt;
  logic            samp_ok, deb_ok, next_samp_ok, next_deb_ok;
  logic            dtick;

  assign raw = {line_adc_i, contact_i, addr_sw_i, opt_sw_i};

  // a bit is taken only after two equal samples one tick apart
  always_comb
  begin
    dtick        = (dcnt == DEB_CYC - 32'h1);
    next_dcnt    = dtick ? 32'h0 : dcnt + 32'h1;
    next_samp    = dtick ? s2 : samp;
    next_deb     = deb;
    next_samp_ok = samp_ok | dtick;
    next_deb_ok  = deb_ok | (dtick & samp_ok);
    if (dtick)
    begin
      next_deb = (deb & (samp ^ s2)) | (s2 & ~(samp ^ s2));
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    s1 <= raw;
    s2 <= s1;
    if (srst_i)
    begin
      dcnt    <= 32'h0;
      samp    <= '0;
      deb     <= '0;
      samp_ok <= 1'b0;
      deb_ok  <= 1'b0;
    end
    else
    begin
      dcnt    <= next_dcnt;
      samp    <= next_samp;
      deb     <= next_deb;
      samp_ok <= next_samp_ok;
      deb_ok  <= next_deb_ok;
    end
  end

  logic [7:0] opt, unit_addr, adc;
  logic       ct_pin;
  assign opt       = deb[7:0];
  assign unit_addr = deb[15:8];
  assign ct_pin    = deb[16];
  assign adc       = deb[24:17];

  // ********************************************************
  // registers
  // ********************************************************
  logic [7:0] nom_clo, nom_opn, nom_tol;
  logic [7:0] next_clo, next_opn, next_tol;
  logic [31:0] next_prdata;
  logic        next_slverr;

  // ********************************************************
  // line supervision and trigger edge
  // ********************************************************
  trf_cls_t cls;
  logic     supv_en, flt, flt_q, ct_lvl, next_lvl, trig;

  always_comb
  begin
    supv_en = opt[SW_SUPV];
    if (near(adc, nom_clo, nom_tol))
      cls = LC_CLOSED;
    else if (near(adc, nom_opn, nom_tol))
      cls = LC_OPEN;
    else
      cls = LC_FAULT;
    flt = supv_en && (cls == LC_FAULT);
    // a faulted line keeps the last good level so it cannot trigger
    if (!supv_en)
      next_lvl = ct_pin;
    else if (flt)
      next_lvl = ct_lvl;
    else
      next_lvl = (cls == LC_OPEN);
    // high level means open: switch two on wants the opening edge
    trig = deb_ok && (next_lvl != ct_lvl)
           && (next_lvl == opt[SW_EDGE]);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ct_lvl <= 1'b0;
      flt_q  <= 1'b0;
    end
    else
    begin
      ct_lvl <= next_lvl;
      flt_q  <= flt;
    end
  end

  // ********************************************************
  // field sequencer
  // ********************************************************
  trf_mode_t        md, mode_q;
  trf_fld_t         st, next_st;
  logic [SEC_W-1:0] sec_left, next_left;
  logic [31:0]      pre_cnt, next_pre;
  logic             sec_tick, restart, mode_chg, stby, duty, mode_ok;

  // first settled mode always loads, so a bad code at reset is still seen
  assign md       = mode_of(opt);
  assign mode_chg = deb_ok && (!mode_ok || md != mode_q);
  assign stby     = (mode_q == MD_STBY);
  assign duty     = is_duty(mode_q);
  assign sec_tick = (pre_cnt == SEC_CYC - 32'h1);

  // prescaler restarts with each phase so phases last whole seconds
  always_comb
  begin
    next_st   = st;
    next_left = sec_left;
    restart   = 1'b0;
    if (mode_chg)
    begin
      restart = 1'b1;
      unique case (md)
        MD_TEST, MD_CONT: next_st = FS_ON;
        MD_STBY:          next_st = FS_OFF;
        MD_DC1, MD_DC2, MD_DC3:
        begin
          next_st   = FS_ON;
          next_left = on_secs(md);
        end
        MD_BAD6, MD_BAD7: next_st = FS_ERR;
      endcase
      if (!is_duty(md))
        next_left = SEC_ZERO;
    end
    else
    begin
      unique case (st)
        FS_OFF:
        begin
          if (stby && trig)
          begin
            next_st   = FS_ON;
            next_left = STBY_ON_S;
            restart   = 1'b1;
          end
          else if (duty && sec_tick)
          begin
            if (sec_left == SEC_ONE)
            begin
              next_st   = FS_ON;
              next_left = on_secs(mode_q);
            end
            else
              next_left = sec_left - SEC_ONE;
          end
        end
        FS_ON:
        begin
          if (stby && trig)
          begin
            next_left = STBY_ON_S;
            restart   = 1'b1;
          end
          else if ((stby || duty) && sec_tick)
          begin
            if (sec_left == SEC_ONE)
            begin
              next_st   = FS_OFF;
              next_left = off_secs(mode_q);
            end
            else
              next_left = sec_left - SEC_ONE;
          end
        end
        FS_ERR: next_st = FS_ERR;
        default: next_st = FS_OFF;
      endcase
    end
    next_pre = (restart || sec_tick) ? 32'h0 : pre_cnt + 32'h1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      st       <= FS_OFF;
      mode_q   <= MD_BAD7;
      mode_ok  <= 1'b0;
      sec_left <= SEC_ZERO;
      pre_cnt  <= 32'h0;
    end
    else
    begin
      st       <= next_st;
      mode_q   <= mode_chg ? md : mode_q;
      mode_ok  <= mode_ok | mode_chg;
      sec_left <= next_left;
      pre_cnt  <= next_pre;
    end
  end

  assign field_en_o = (st == FS_ON);

  // ********************************************************
  // continuous mode query and reacquire pulses
  // ********************************************************
  logic [3:0] q_sec, next_q;
  logic [5:0] a_sec, next_a;
  logic       cont, next_query, next_reacq;

  always_comb
  begin
    cont       = (mode_q == MD_CONT) && !mode_chg;
    next_query = cont && sec_tick && (q_sec == QUERY_LAST);
    next_reacq = cont && sec_tick && (a_sec == REACQ_LAST);
    next_q     = q_sec;
    next_a     = a_sec;
    if (!cont)
    begin
      next_q = 4'h0;
      next_a = 6'h00;
    end
    else if (sec_tick)
    begin
      next_q = next_query ? 4'h0 : q_sec + 4'h1;
      next_a = next_reacq ? 6'h00 : a_sec + 6'h01;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      q_sec   <= 4'h0;
      a_sec   <= 6'h00;
      query_o <= 1'b0;
      reacq_o <= 1'b0;
    end
    else
    begin
      q_sec   <= next_q;
      a_sec   <= next_a;
      query_o <= next_query;
      reacq_o <= next_reacq;
    end
  end

  // ********************************************************
  // report slot: errors outrank tags
  // ********************************************************
  trf_rpt_t rpt, next_rpt;
  logic     rpt_v, pend_err, pend_flt, fwd_md, tag_take;
  logic     next_v, next_perr, next_pflt, set_err, set_flt;

  assign fwd_md      = field_en_o && (mode_q != MD_TEST);
  assign tag_ready_o = !fwd_md || !(rpt_v || pend_err || pend_flt);
  assign tag_take    = tag_valid_i && tag_ready_o;

  // a new error set wins over the clear of the same cycle
  always_comb
  begin
    set_err   = mode_chg && (md == MD_BAD6 || md == MD_BAD7);
    set_flt   = flt && !flt_q;
    next_v    = rpt_v && !rpt_ready_i;
    next_rpt  = rpt;
    next_perr = pend_err;
    next_pflt = pend_flt;
    if (!rpt_v)
    begin
      next_rpt.unit = unit_addr;
      next_rpt.tag  = 32'h0;
      if (pend_err)
      begin
        next_v        = 1'b1;
        next_rpt.kind = MK_MODE_ERR;
        next_perr     = 1'b0;
      end
      else if (pend_flt)
      begin
        next_v        = 1'b1;
        next_rpt.kind = MK_LINE_FLT;
        next_pflt     = 1'b0;
      end
      else if (tag_take && fwd_md)
      begin
        next_v        = 1'b1;
        next_rpt.kind = MK_TAG;
        next_rpt.tag  = tag_id_i;
      end
    end
    next_perr = next_perr | set_err;
    next_pflt = next_pflt | set_flt;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      rpt_v    <= 1'b0;
      rpt      <= '0;
      pend_err <= 1'b0;
      pend_flt <= 1'b0;
    end
    else
    begin
      rpt_v    <= next_v;
      rpt      <= next_rpt;
      pend_err <= next_perr;
      pend_flt <= next_pflt;
    end
  end

  assign rpt_valid_o = rpt_v;
  assign rpt_o       = rpt;

  // ********************************************************
  // indicators
  // ********************************************************
  logic [31:0] pl_cnt, next_pl;
  logic        ind_en;

  always_comb
  begin
    ind_en  = opt[SW_IND];
    next_pl = (pl_cnt != 32'h0) ? pl_cnt - 32'h1 : 32'h0;
    if (tag_take && field_en_o && ind_en)
      next_pl = PULSE_CYC;
    if (!ind_en)
      next_pl = 32'h0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      pl_cnt      <= 32'h0;
      red_led_o   <= 1'b0;
      buzzer_o    <= 1'b0;
      green_led_o <= 1'b0;
    end
    else
    begin
      pl_cnt      <= next_pl;
      red_led_o   <= (next_pl != 32'h0);
      buzzer_o    <= (next_pl != 32'h0);
      green_led_o <= (next_st == FS_ON) && ind_en;
    end
  end

  // ********************************************************
  // APB slave, zero wait; read data captured in setup
  // ********************************************************
  logic setup, hit_nom, hit_stat;

  assign pready_o = 1'b1;
  assign setup    = psel_i && !penable_i;
  assign hit_nom  = (paddr_i == REG_NOM);
  assign hit_stat = (paddr_i == REG_STAT);

  always_comb
  begin
    next_clo    = nom_clo;
    next_opn    = nom_opn;
    next_tol    = nom_tol;
    next_prdata = 32'h0;
    next_slverr = pslverr_o;
    if (psel_i && penable_i && pwrite_i && hit_nom)
    begin
      next_clo = pwdata_i[NOM_CLO_LSB +: 8];
      next_opn = pwdata_i[NOM_OPN_LSB +: 8];
      next_tol = pwdata_i[NOM_TOL_LSB +: 8];
    end
    if (setup)
    begin
      next_slverr = !(hit_nom || hit_stat);
      if (hit_nom)
      begin
        next_prdata[NOM_CLO_LSB +: 8] = nom_clo;
        next_prdata[NOM_OPN_LSB +: 8] = nom_opn;
        next_prdata[NOM_TOL_LSB +: 8] = nom_tol;
      end
      else if (hit_stat)
      begin
        next_prdata[ST_MODE_LSB +: 3] = mode_q;
        next_prdata[ST_FSM_LSB +: 3]  = st;
        next_prdata[ST_FLT_BIT]       = flt;
        next_prdata[ST_CLS_LSB +: 2]  = cls;
        next_prdata[ST_ADDR_LSB +: 8] = unit_addr;
      end
    end
    else if (!psel_i)
      next_slverr = 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      nom_clo   <= NOM_CLO_RST;
      nom_opn   <= NOM_OPN_RST;
      nom_tol   <= NOM_TOL_RST;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      nom_clo   <= next_clo;
      nom_opn   <= next_opn;
      nom_tol   <= next_tol;
      prdata_o  <= setup ? next_prdata : prdata_o;
      pslverr_o <= next_slverr;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_trig;
    mode_q == MD_STBY && trig && !mode_chg;
  endsequence

  sequence s_bad_entry;
    mode_chg && (md == MD_BAD6 || md == MD_BAD7);
  endsequence

  a_test_field: assert property (
    mode_q == MD_TEST && !mode_chg |-> field_en_o)
    else $error("field off in test mode");

  a_test_silent: assert property (
    mode_q == MD_TEST && !rpt_v && !mode_chg
      |=> !(rpt_v && rpt.kind == MK_TAG))
    else $error("tag reported in test mode");

  a_tag_beep: assert property (
    tag_take && field_en_o && ind_en |=> red_led_o && buzzer_o)
    else $error("no indication for tag");

  a_query_tick: assert property (
    mode_q == MD_CONT && !mode_chg && sec_tick && q_sec == QUERY_LAST
      |=> query_o ##1 !query_o)
    else $error("query pulse missing");

  a_stby_open: assert property (
    s_trig |=> field_en_o && sec_left == STBY_ON_S)
    else $error("standby trigger did not open field");

  a_duty_off: assert property (
    field_en_o && duty && !mode_chg && sec_tick && sec_left == SEC_ONE
      |=> !field_en_o && sec_left == off_secs(mode_q))
    else $error("duty off phase wrong");

  a_bad_err: assert property (
    s_bad_entry |=> st == FS_ERR && pend_err ##1 rpt_v || pend_err)
    else $error("undefined mode not flagged");

  sequence s_flt_rise;
    flt && !flt_q;
  endsequence

  // the network may stall, so latch and send are checked apart
  a_line_fault: assert property (
    s_flt_rise |=> pend_flt)
    else $error("line fault not latched");

  a_flt_send: assert property (
    pend_flt && !pend_err && !rpt_v |=> rpt_v && rpt.kind == MK_LINE_FLT)
    else $error("line fault not reported");

endmodule : trf_field_ctrl

// ### trf_far_model.sv
`timescale 1ns/100ps
// ********************************************************
// radio front end and network transmitter model
// ********************************************************
module trf_far_model
  import trf_pkg::*;
(
  input  logic        clk_sys_i,
  input  logic        srst_i,
  input  logic        send_i,
  input  logic [31:0] id_i,
  input  logic        slow_i,
  input  logic        tag_ready_i,
  output logic        tag_valid_o,
  output logic [31:0] tag_id_o,
  input  logic        rpt_valid_i,
  output logic        rpt_ready_o
);
  logic [1:0] stall;

  // radio: hold the event until taken; idle id lines invert every cycle instead of holding old data
  always @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      tag_valid_o <= 1'b0;
      tag_id_o    <= 32'h0;
    end
    else if (send_i)
    begin
      tag_valid_o <= 1'b1;
      tag_id_o    <= id_i;
    end
    else if (tag_valid_o && tag_ready_i)
    begin
      tag_valid_o <= 1'b0;
      tag_id_o    <= ~tag_id_o;
    end
    else if (!tag_valid_o)
      tag_id_o <= ~tag_id_o;
  end

  // network side: accepts at once, or one cycle in four when slow
  always @(posedge clk_sys_i)
  begin
    stall       <= srst_i ? 2'h0 : stall + 2'h1;
    rpt_ready_o <= !srst_i && (!slow_i || stall == 2'h3);
  end
endmodule : trf_far_model

// ### tb.sv
`timescale 1ns/100ps
module tb
  import trf_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic [7:0]  opt_sw    = 8'h00;
  logic [7:0]  addr_sw   = 8'h00;
  logic [7:0]  line_adc  = 8'h30;
  logic        contact   = 1'b0;
  logic        psel      = 1'b0;
  logic        pen       = 1'b0;
  logic        pwr       = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic        send      = 1'b0;
  logic        slow      = 1'b0;
  logic [31:0] sid       = 32'h0;
  logic [31:0] seed      = 32'hE1D2A00C;
  logic [31:0] prdata, r;
  logic        pready, pslverr, e, tag_valid, tag_ready, rpt_valid;
  logic        rpt_ready, field, query, red, buzz, reacq, green;
  logic [31:0] tag_id;
  trf_rpt_t    rpt;
  trf_rpt_t    expq[$];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          n, i, m;
  logic [7:0]  dsw[3]  = '{8'hC4, 8'h24, 8'hA4};
  int          don[3]  = '{100, 200, 200};
  int          doff[3] = '{600, 6000, 36000};

  always #20 clk_sys_i = ~clk_sys_i;

  trf_field_ctrl #(.SEC_CYC(20), .DEB_CYC(4), .PULSE_CYC(3)) dut_u (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .opt_sw_i(opt_sw),
    .addr_sw_i(addr_sw), .contact_i(contact), .line_adc_i(line_adc),
    .tag_valid_i(tag_valid), .tag_id_i(tag_id), .tag_ready_o(tag_ready),
    .rpt_valid_o(rpt_valid), .rpt_o(rpt), .rpt_ready_i(rpt_ready),
    .field_en_o(field), .query_o(query), .reacq_o(reacq), .red_led_o(red),
    .green_led_o(green), .buzzer_o(buzz), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

  trf_far_model far_u (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .send_i(send), .id_i(sid),
    .slow_i(slow), .tag_ready_i(tag_ready), .tag_valid_o(tag_valid),
    .tag_id_o(tag_id), .rpt_valid_i(rpt_valid), .rpt_ready_o(rpt_ready));

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    samples_checked++;
    if (g !== x)
    begin
      $display("BAD %0t exp %h got %h", $time, x, g);
      mismatches++;
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // switch change, then room for sync and debounce to settle
  task automatic setsw(input logic [7:0] v);
    @(posedge clk_sys_i) opt_sw <= v;
    repeat (40) @(posedge clk_sys_i);
  endtask : setsw

  task automatic wfield(input logic v);
    for (m = 0; m < 900 && field !== v; m++)
      @(posedge clk_sys_i) #1;
    if (field !== v)
    begin
      mismatches++;
      final_report;
    end
  endtask : wfield

  // cycles the field stays at its present level
  task automatic span(output int k);
    logic v;
    v = field;
    k = 0;
    while (field === v && k < 40000)
    begin
      @(posedge clk_sys_i) #1;
      k++;
    end
  endtask : span

  task automatic tag(input logic rep, input trf_kind_t kd);
    seed = lfsr(seed);
    if (rep)
      expq.push_back('{kd, addr_sw, seed});
    @(posedge clk_sys_i)
    begin
      send <= 1'b1;
      sid  <= seed;
    end
    @(posedge clk_sys_i) send <= 1'b0;
  endtask : tag

  // one transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i)
    begin
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    end
    @(posedge clk_sys_i) pen <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_sys_i);
      if (pready === 1'b1)
        break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (i == 20)
    begin
      mismatches++;
      final_report;
    end
  endtask : apb

  // report watcher: oldest note against each accepted report
  always @(posedge clk_sys_i)
    if (rpt_valid === 1'b1 && rpt_ready === 1'b1)
    begin
      if (expq.size() == 0)
        chk(rpt, 64'hFFFF);
      else
        chk(rpt, expq.pop_front());
    end

  // ********************************************************
  // main sequence
  // ********************************************************
  initial
  begin
    seed = lfsr(seed);
    addr_sw = seed[7:0];
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    apb(1'b0, REG_NOM, 32'h0);
    chk(r[23:0], 24'h10C040);
    apb(1'b1, REG_NOM, 32'h0008D030);
    apb(1'b0, REG_NOM, 32'h0);
    chk(r[23:0], 24'h08D030);
    apb(1'b0, 8'h08, 32'h0);
    chk(e, 1'b1);
    setsw(8'h04);
    apb(1'b0, REG_STAT, 32'h0);
    chk(r[23:16], addr_sw);
    chk(r[2:0], MD_TEST);
    $display("test registers done");
    wfield(1'b1);
    tag(1'b0, MK_TAG);
    for (n = 0; n < 20 && red !== 1'b1; n++)
      @(posedge clk_sys_i) #1;
    chk({red, buzz, green}, 3'b111);
    repeat (20) @(posedge clk_sys_i);
    setsw(8'h00);
    tag(1'b0, MK_TAG);
    repeat (10) @(posedge clk_sys_i) #1;
    chk({field, red, buzz, green}, 4'b1000);
    $display("test test mode done");
    slow <= 1'b1;
    setsw(8'h84);
    wfield(1'b1);
    tag(1'b1, MK_TAG);
    tag(1'b1, MK_TAG);
    for (n = 0; n < 260 && query !== 1'b1; n++)
      @(posedge clk_sys_i) #1;
    chk(query, 1'b1);
    for (n = 0; n < 1300 && reacq !== 1'b1; n++)
      @(posedge clk_sys_i) #1;
    chk(reacq, 1'b1);
    expq.push_back('{MK_LINE_FLT, addr_sw, 32'h0});
    setsw(8'h85);
    line_adc <= 8'h80;
    repeat (40) @(posedge clk_sys_i);
    line_adc <= 8'h30;
    setsw(8'h84);
    $display("test continuous done");
    for (int k = 0; k < 3; k++)
    begin
      setsw(dsw[k]);
      wfield(1'b1);
      wfield(1'b0);
      span(n);
      chk(n, doff[k]);
      span(n);
      chk(n, don[k]);
    end
    $display("test duty cycle done");
    setsw(8'h46);
    wfield(1'b0);
    @(posedge clk_sys_i) contact <= 1'b1;
    wfield(1'b1);
    fork
      span(n);
      tag(1'b1, MK_TAG);
    join
    chk(n, 200);
    @(posedge clk_sys_i) contact <= 1'b0;
    repeat (60) @(posedge clk_sys_i) #1;
    chk(field, 1'b0);
    // supervised line: open level triggers, a second one restarts
    setsw(8'h47);
    line_adc <= 8'hD0;
    wfield(1'b1);
    repeat (100) @(posedge clk_sys_i);
    line_adc <= 8'h30;
    repeat (40) @(posedge clk_sys_i);
    line_adc <= 8'hD0;
    repeat (120) @(posedge clk_sys_i) #1;
    chk(field, 1'b1);
    $display("test standby done");
    expq.push_back('{MK_MODE_ERR, addr_sw, 32'h0});
    setsw(8'h64);
    chk(field, 1'b0);
    expq.push_back('{MK_MODE_ERR, addr_sw, 32'h0});
    setsw(8'hE4);
    for (n = 0; n < 200 && expq.size() != 0; n++)
      @(posedge clk_sys_i);
    chk(expq.size(), 0);
    $display("test error mode done");
    final_report;
  end
endmodule : tb
